// ==== shared/brt_pkg.sv ====
// brt_pkg: register map, field positions and codes of the reload timer
package brt_pkg;
  localparam int AW = 4;
  localparam int DW = 16;
  // register byte addresses
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_STAT  = 4'h4;
  localparam logic [3:0] ADDR_CYCLE = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  // timer_control_register fields
  localparam int CTRL_TRIG  = 0;
  localparam int CTRL_RUN   = 1;
  localparam int CTRL_ONE   = 2;
  localparam int CTRL_INV   = 3;
  localparam int CTRL_FN    = 4;
  localparam int CTRL_WIDE  = 7;
  localparam int CTRL_EDGE  = 8;
  localparam int CTRL_CKS   = 12;
  localparam logic [15:0] CTRL_WMASK = 16'h73FE;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  // status_control_register low byte, control_b high byte
  localparam int STAT_FLAG  = 0;
  localparam int STAT_IE    = 4;
  localparam int STAT_CKSH  = 8;
  localparam int STAT_GATE  = 15;
  localparam logic [15:0] CYCLE_RST = 16'h0000;
  localparam logic [2:0] FN_RELOAD = 3'h3;
  // count clock select codes
  localparam logic [3:0] CKS_D1    = 4'h0;
  localparam logic [3:0] CKS_D4    = 4'h1;
  localparam logic [3:0] CKS_D16   = 4'h2;
  localparam logic [3:0] CKS_D128  = 4'h3;
  localparam logic [3:0] CKS_D256  = 4'h4;
  localparam logic [3:0] CKS_EXTR  = 4'h5;
  localparam logic [3:0] CKS_EXTF  = 4'h6;
  localparam logic [3:0] CKS_EXTB  = 4'h7;
  localparam logic [3:0] CKS_D512  = 4'h8;
  localparam logic [3:0] CKS_D1024 = 4'h9;
  localparam logic [3:0] CKS_D2048 = 4'hA;
  // edge select codes in trigger mode
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int PRESC_W = 11;
  typedef enum logic [2:0] {
    BRT_ST_STOP = 3'b001,
    BRT_ST_WAIT = 3'b010,
    BRT_ST_RUN  = 3'b100
  } brt_state_t;
endpackage

// ==== design/brt_pin_sampler.sv ====
// brt_pin_sampler: pin delay line with level and edge outputs
`timescale 1ns/1ps
`default_nettype none
module brt_pin_sampler (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // pin side
  input  wire logic pin,
  // sampled outputs
  output wire logic level,
  output wire logic rise,
  output wire logic fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // three stages give the 2T..3T pin-to-load latency
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
  assign fall  = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ==== design/brt_reload_timer.sv ====
// brt_reload_timer: 16-bit reload timer channel with register port
//
// Contract
// R1: reload function plus wide bit chains the channel as 32-bit upper half.
// R2: counter decrements from cycle value once per count clock event.
// R3: one write setting run and soft trigger enables and starts together.
// R4: any start trigger while enabled loads cycle value; soft load after 1T.
// R5: underflow is the wrap from 0x0000; period is cycle value plus one.
// R6: underflow reloads; reload mode continues, one-shot halts holding value.
// R7: underflow sets flag; interrupt only while underflow enable is one.
// R8: trigger mode valid pin edge loads and starts within 2T to 3T.
// R9: gate mode counts only while pin level valid, 2T to 3T latency.
// R10: output toggles per underflow in reload, pulse while counting one-shot.
// R11: invert clear: toggle starts 0, pulse high; set inverts both.
// R12: four-bit select picks machine clock divisor or external edge.
// R13: count clock select acts at once; change only while stopped.
// R14: edge select 00 off, 01 rise, 10 fall, 11 both edges.
// R15: gate level: codes 00 and 10 low, 01 and 11 high.
// R16: soft trigger starts timer whatever the edge select is.
// R17: software changes edge select only while stopped or with enable.
// R18: gate enable bit chooses trigger (0) or gate (1) pin use.
// R19: clearing run enable stops the counter and drives output low.
// R20: in 32-bit mode software writes upper cycle half first.
// R21: after one-shot stop a new trigger restarts the countdown.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module brt_reload_timer (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [brt_pkg::AW-1:0]  reg_addr,
  input  wire logic [brt_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [brt_pkg::DW-1:0]  reg_rdata,
  // pins
  input  wire logic                    ext_trigger_pin,
  input  wire logic                    ext_clock_pin,
  output logic                         timer_output_pin,
  // channel chaining and interrupt
  input  wire logic                    chain_underflow_in,
  output logic                         chain_underflow_out,
  output logic                         underflow_irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [15:0]         ctrl_q;
  logic [15:0]         ctrl_d;
  logic                gate_q;
  logic                cksh_q;
  logic                ie_q;
  logic                flag_q;
  logic                flag_d;
  logic [15:0]         cycle_q;
  logic [15:0]         cnt_q;
  logic [15:0]         cnt_d;
  logic                tog_q;
  logic                tog_d;
  logic                out_d;
  logic [brt_pkg::PRESC_W-1:0] presc_q;
  logic [brt_pkg::DW-1:0] rdata_d;
  brt_pkg::brt_state_t state_q;
  brt_pkg::brt_state_t state_d;

  wire ctrl_wr_w  = reg_wr && (reg_addr == brt_pkg::ADDR_CTRL);
  wire stat_wr_w  = reg_wr && (reg_addr == brt_pkg::ADDR_STAT);
  wire cycle_wr_w = reg_wr && (reg_addr == brt_pkg::ADDR_CYCLE);

  // field views of the stored and next control words, and state decodes
  wire       run_q   = ctrl_q[brt_pkg::CTRL_RUN];
  wire       one_q   = ctrl_q[brt_pkg::CTRL_ONE];
  wire       inv_q   = ctrl_q[brt_pkg::CTRL_INV];
  wire       wide_q  = ctrl_q[brt_pkg::CTRL_WIDE];
  wire [2:0] fn_q    = ctrl_q[brt_pkg::CTRL_FN +: 3];
  wire [1:0] edge_q  = ctrl_q[brt_pkg::CTRL_EDGE +: 2];
  wire [3:0] cks_w   = {cksh_q, ctrl_q[brt_pkg::CTRL_CKS +: 3]};
  wire       run_d   = ctrl_d[brt_pkg::CTRL_RUN];
  wire       fn_ok_d = ctrl_d[brt_pkg::CTRL_FN +: 3] == brt_pkg::FN_RELOAD;
  wire       st_stop = state_q == brt_pkg::BRT_ST_STOP;
  wire       st_run  = state_q == brt_pkg::BRT_ST_RUN;

  // new settings act at once; software keeps them still while running
  // R13: immediate select
  // R17: write while stopped
  assign ctrl_d = ctrl_wr_w ? (reg_wdata & brt_pkg::CTRL_WMASK) : ctrl_q;

  ////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic trg_lvl;
  logic trg_rise;
  logic trg_fall;
  logic eck_rise;
  logic eck_fall;

  brt_pin_sampler u_trig_pin (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (ext_trigger_pin),
    .level    (trg_lvl),
    .rise     (trg_rise),
    .fall     (trg_fall)
  );

  brt_pin_sampler u_clk_pin (
    .core_clk (core_clk),
    .reset    (reset),
    .pin      (ext_clock_pin),
    .level    (),
    .rise     (eck_rise),
    .fall     (eck_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // count clock: free prescaler, taps ANDed so each divisor ticks once
  logic clk_tick;

  // R12: count clock select
  always_comb begin
    clk_tick = 1'b0;
    unique case (cks_w)
      brt_pkg::CKS_D1:    clk_tick = 1'b1;
      brt_pkg::CKS_D4:    clk_tick = &presc_q[1:0];
      brt_pkg::CKS_D16:   clk_tick = &presc_q[3:0];
      brt_pkg::CKS_D128:  clk_tick = &presc_q[6:0];
      brt_pkg::CKS_D256:  clk_tick = &presc_q[7:0];
      brt_pkg::CKS_EXTR:  clk_tick = eck_rise;
      brt_pkg::CKS_EXTF:  clk_tick = eck_fall;
      brt_pkg::CKS_EXTB:  clk_tick = eck_rise | eck_fall;
      brt_pkg::CKS_D512:  clk_tick = &presc_q[8:0];
      brt_pkg::CKS_D1024: clk_tick = &presc_q[9:0];
      brt_pkg::CKS_D2048: clk_tick = &presc_q;
      // prohibited codes never count
      default:            clk_tick = 1'b0;
    endcase
  end

  // R1: chained upper half
  wire cnt_evt = wide_q ? chain_underflow_in : clk_tick;

  ////////////////////////////////////////////////////////////////////////
  // trigger and gate decode
  // R18: gate or trigger
  // R15: gate level
  wire gate_ok = !gate_q || (trg_lvl == edge_q[0]);

  // R14: edge select
  wire ext_edge =
    ((edge_q == brt_pkg::EDGE_RISE) && trg_rise) ||
    ((edge_q == brt_pkg::EDGE_FALL) && trg_fall) ||
    ((edge_q == brt_pkg::EDGE_BOTH) && (trg_rise || trg_fall));

  // R8: edge starts timer
  // R21: restart after halt
  wire ext_start = !gate_q && ext_edge && !st_stop;

  // R3: enable plus trigger
  // R16: soft ignores edge
  wire soft_start = ctrl_wr_w && reg_wdata[brt_pkg::CTRL_RUN] &&
                    reg_wdata[brt_pkg::CTRL_TRIG];

  wire start_w = run_d && fn_ok_d && (soft_start || ext_start);
  wire active  = run_d && fn_ok_d;

  // R5: wrap from zero
  // R9: gated decrement
  wire dec_w   = active && !start_w && st_run && cnt_evt && gate_ok;
  wire uflow_w = dec_w && (cnt_q == 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // counter state machine
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    tog_d   = tog_q;
    if (!active) begin
      // R19: stop on disable
      state_d = brt_pkg::BRT_ST_STOP;
    end else if (start_w) begin
      // R4: load cycle value
      state_d = brt_pkg::BRT_ST_RUN;
      cnt_d   = cycle_q;
      tog_d   = 1'b0;
    end else if (uflow_w) begin
      // R6: reload and continue or halt
      cnt_d   = cycle_q;
      tog_d   = ~tog_q;
      if (one_q) begin
        state_d = brt_pkg::BRT_ST_WAIT;
      end
    end else if (dec_w) begin
      // R2: decrement
      cnt_d = cnt_q - 16'h0001;
    end else if (st_stop) begin
      state_d = brt_pkg::BRT_ST_WAIT;
    end
  end

  // R10: toggle or pulse
  // R11: polarity
  assign out_d = !run_q ? 1'b0 :
                 one_q  ? (st_run ^ inv_q) : (tog_q ^ inv_q);

  // R7: set wins over clear
  assign flag_d = uflow_w |
                  (flag_q & ~(stat_wr_w & ~reg_wdata[brt_pkg::STAT_FLAG]));

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        brt_pkg::ADDR_CTRL:  rdata_d = ctrl_q;
        brt_pkg::ADDR_STAT:  rdata_d = {gate_q, 6'h00, cksh_q, 3'h0,
                                        ie_q, 3'h0, flag_q};
        brt_pkg::ADDR_CYCLE: rdata_d = cycle_q;
        brt_pkg::ADDR_COUNT: rdata_d = cnt_q;
        default:             rdata_d = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q  <= brt_pkg::CTRL_RST;
      gate_q  <= 1'b0;
      cksh_q  <= 1'b0;
      ie_q    <= 1'b0;
      cycle_q <= brt_pkg::CYCLE_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (stat_wr_w) begin
        gate_q <= reg_wdata[brt_pkg::STAT_GATE];
        cksh_q <= reg_wdata[brt_pkg::STAT_CKSH];
        ie_q   <= reg_wdata[brt_pkg::STAT_IE];
      end
      if (cycle_wr_w) begin
        cycle_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= brt_pkg::BRT_ST_STOP;
      cnt_q   <= 16'h0000;
      tog_q   <= 1'b0;
      flag_q  <= 1'b0;
      presc_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      tog_q   <= tog_d;
      flag_q  <= flag_d;
      presc_q <= presc_q + brt_pkg::PRESC_W'(1'b1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata           <= '0;
      timer_output_pin    <= 1'b0;
      chain_underflow_out <= 1'b0;
      underflow_irq       <= 1'b0;
    end else begin
      reg_rdata           <= rdata_d;
      timer_output_pin    <= out_d;
      chain_underflow_out <= uflow_w;
      // R7: masked request
      underflow_irq       <= flag_q & ie_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_soft_go;
    soft_start && fn_ok_d;
  endsequence

  sequence s_loaded;
    st_run && (cnt_q == $past(cycle_q));
  endsequence

  AST_SOFT_LOAD: assert property (s_soft_go |=> s_loaded) // R4
    else $error("soft trigger did not load cycle value in one cycle");

  AST_EXT_LOAD: assert property (ext_start && active |=> s_loaded) // R8
    else $error("pin edge did not load cycle value");

  AST_DECR: assert property (dec_w && (cnt_q != 16'h0000) |=> // R2
    cnt_q == $past(cnt_q) - 16'h0001)
    else $error("counter did not decrement by one");

  AST_RELOAD: assert property (uflow_w |=> cnt_q == $past(cycle_q)) // R6
    else $error("underflow did not reload cycle value");

  AST_ONESHOT_HALT: assert property (uflow_w && one_q |=> !st_run) // R6
    else $error("one-shot kept counting after underflow");

  AST_FLAG_SET: assert property (uflow_w |=> flag_q) // R7
    else $error("underflow flag not set");

  AST_IRQ_MASK: assert property (!ie_q |=> !underflow_irq) // R7
    else $error("interrupt raised while masked");

  AST_STOP_LOW: assert property ( // R19
    ctrl_wr_w && !reg_wdata[brt_pkg::CTRL_RUN] |=> ##1 !timer_output_pin)
    else $error("output not low after disable");

  AST_EDGE_OFF: assert property ( // R14
    !st_run && !gate_q && (edge_q == brt_pkg::EDGE_OFF) && !soft_start
    |=> !st_run)
    else $error("timer started with external trigger disabled");

  AST_GATE_HOLD: assert property ( // R15
    st_run && gate_q && (trg_lvl != edge_q[0]) && !start_w
    |=> cnt_q == $past(cnt_q))
    else $error("counter moved outside gate level");

  AST_TOGGLE: assert property ( // R10
    uflow_w && !one_q && !ctrl_wr_w ##1 run_q
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle on underflow");

  AST_CHAIN_OUT: assert property (uflow_w |=> chain_underflow_out) // R5
    else $error("underflow pulse missing on chain output");

  AST_IRQ_SET: assert property (flag_q && ie_q |=> underflow_irq) // R7
    else $error("interrupt not raised for enabled flag");

  AST_OFF_LOW: assert property (!run_q |=> !timer_output_pin) // R19
    else $error("output high while run enable clear");

  AST_WAIT_HOLD: assert property ( // R6
    (state_q == brt_pkg::BRT_ST_WAIT) && !start_w |=> cnt_q == $past(cnt_q))
    else $error("counter moved while waiting for a trigger");

  AST_PULSE_HIGH: assert property ( // R11
    run_q && one_q && !inv_q && st_run |=> timer_output_pin)
    else $error("one-shot pulse not high while counting");

  AST_FN_STOP: assert property ( // R1
    (fn_q != brt_pkg::FN_RELOAD) && !ctrl_wr_w |=> st_stop)
    else $error("timer left stop with another function selected");
endmodule
`default_nettype wire

// ==== tb/brt_pin_partner.sv ====
// brt_pin_partner: trigger/gate pin and external count clock source
`timescale 1ns/1ps
`default_nettype none
module brt_pin_partner (
  // clock
  input  wire logic core_clk,
  // commands from the bench
  input  wire logic clk_run,
  input  wire logic trig_req,
  // pins toward the timer
  output logic      ext_trigger_pin,
  output logic      ext_clock_pin
);
  logic [1:0] div_q;
  initial begin
    div_q = 2'h0;
    ext_clock_pin = 1'b0;
    ext_trigger_pin = 1'b0;
  end
  // pins move only at core edges; the clock stands still when not running
  always @(posedge core_clk) begin
    ext_trigger_pin <= trig_req;
    if (clk_run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) ext_clock_pin <= ~ext_clock_pin;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: register-level tests of the reload timer channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                   core_clk;
  logic                   reset;
  logic [brt_pkg::AW-1:0] reg_addr;
  logic [brt_pkg::DW-1:0] reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [brt_pkg::DW-1:0] reg_rdata;
  logic                   trg_pin;
  logic                   ext_clk;
  logic                   out_pin;
  logic                   chain_in;
  logic                   chain_out;
  logic                   irq;
  logic                   clk_run;
  logic                   trig_req;
  logic [15:0]            a;
  logic [15:0]            b;
  int                     n;
  int                     n_fail;
  int                     n_checks;
  int ck[11]  = '{0, 1, 2, 3, 4, 8, 9, 10, 5, 6, 7};
  int per[11] = '{2, 8, 32, 256, 512, 1024, 2048, 4096, 16, 16, 8};

  brt_reload_timer u_dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trigger_pin(trg_pin),
    .ext_clock_pin(ext_clk), .timer_output_pin(out_pin),
    .chain_underflow_in(chain_in), .chain_underflow_out(chain_out),
    .underflow_irq(irq));
  brt_pin_partner u_pins (
    .core_clk(core_clk), .clk_run(clk_run), .trig_req(trig_req),
    .ext_trigger_pin(trg_pin), .ext_clock_pin(ext_clk));

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // settle past the edge so registered outputs are read safely
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // edges until the output is high; 0 means the bound ran out
  task automatic wait_hi(input bit sel, input int bound, output int c);
    c = 0;
    for (int i = 1; i <= bound && c == 0; i++) begin
      @(posedge core_clk);
      #1;
      if ((sel ? out_pin : chain_out) === 1'b1) c = i;
    end
  endtask
  // first period may be partial, so the second is measured
  task automatic period(input int bound, output int c);
    wait_hi(1'b0, bound, c);
    wait_hi(1'b0, bound, c);
    if (c == 0) begin
      n_fail++;
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chain_in = 1'b0;
    clk_run = 1'b0;
    trig_req = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    // reset values, unmapped and read-only places
    for (int i = 0; i < 14; i += 2) begin
      rd(i[3:0], a);
      chk(a, 16'h0000);
    end
    wr(brt_pkg::ADDR_COUNT, 16'h1234);
    rd(brt_pkg::ADDR_COUNT, a);
    chk(a, 16'h0000);
    wr(brt_pkg::ADDR_CTRL, 16'hFFFF);
    rd(brt_pkg::ADDR_CTRL, a);
    chk(a, brt_pkg::CTRL_WMASK);
    wr(brt_pkg::ADDR_CTRL, 16'h0000);
    // soft start together with enable, then count down
    wr(brt_pkg::ADDR_CYCLE, 16'h03E8);
    wr(brt_pkg::ADDR_CTRL, 16'h0033);
    rd(brt_pkg::ADDR_COUNT, a);
    rd(brt_pkg::ADDR_COUNT, b);
    chk(a == 16'h03E8 || a == 16'h03E7, 16'h0001);
    chk(a - b, 16'h0002);
    // toggle output both polarities, then stop
    for (int v = 0; v < 2; v++) begin
      wr(brt_pkg::ADDR_CTRL, 16'h0000);
      wr(brt_pkg::ADDR_CYCLE, 16'h0005);
      wr(brt_pkg::ADDR_CTRL, v[0] ? 16'h003B : 16'h0033);
      cyc(3);
      chk(out_pin, v[0]);
      period(100, n);
      chk(n, 16'd6);
      wait_hi(1'b0, 100, n);
      chk(n, 16'h0006);
      cyc(1);
      chk(out_pin, {15'h0000, ~v[0]});
      wr(brt_pkg::ADDR_CTRL, v[0] ? 16'h0038 : 16'h0030);
      cyc(3);
      chk(out_pin, 16'h0000);
      rd(brt_pkg::ADDR_COUNT, a);
      rd(brt_pkg::ADDR_COUNT, b);
      chk(b, a);
    end
    // one-shot pulse, held reload value, flag and irq, restart
    wr(brt_pkg::ADDR_CYCLE, 16'h0014);
    wr(brt_pkg::ADDR_STAT, 16'h0000);
    wr(brt_pkg::ADDR_CTRL, 16'h0037);
    cyc(3);
    chk(out_pin, 16'h0001);
    wait_hi(1'b0, 100, n);
    chk(n, 16'h0012);
    cyc(3);
    chk(out_pin, 16'h0000);
    rd(brt_pkg::ADDR_COUNT, a);
    rd(brt_pkg::ADDR_COUNT, b);
    chk(a, 16'h0014);
    chk(b, 16'h0014);
    rd(brt_pkg::ADDR_STAT, a);
    chk(a, 16'h0001);
    chk(irq, 16'h0000);
    wr(brt_pkg::ADDR_STAT, 16'h0011);
    cyc(2);
    chk(irq, 16'h0001);
    rd(brt_pkg::ADDR_STAT, a);
    chk(a, 16'h0011);
    wr(brt_pkg::ADDR_STAT, 16'h0010);
    cyc(2);
    chk(irq, 16'h0000);
    rd(brt_pkg::ADDR_STAT, a);
    chk(a, 16'h0010);
    wr(brt_pkg::ADDR_CTRL, 16'h0037);
    wait_hi(1'b0, 100, n);
    chk(n >= 20 && n <= 24, 16'h0001);
    // every count clock code, internal and external
    clk_run <= 1'b1;
    wr(brt_pkg::ADDR_CYCLE, 16'h0001);
    for (int i = 0; i < 11; i++) begin
      wr(brt_pkg::ADDR_CTRL, 16'h0000);
      wr(brt_pkg::ADDR_STAT, ck[i][3] ? 16'h0100 : 16'h0000);
      wr(brt_pkg::ADDR_CTRL, 16'h0033 | {1'b0, ck[i][2:0], 12'h000});
      period(5000, n);
      chk(n, per[i][15:0]);
    end
    wr(brt_pkg::ADDR_CTRL, 16'h0000);
    wr(brt_pkg::ADDR_STAT, 16'h0100);
    wr(brt_pkg::ADDR_CTRL, 16'h3033);
    wait_hi(1'b0, 300, n);
    chk(n, 16'h0000);
    clk_run <= 1'b0;
    // trigger pin edge codes, soft start with triggering off
    wr(brt_pkg::ADDR_STAT, 16'h0000);
    wr(brt_pkg::ADDR_CYCLE, 16'h00C8);
    for (int e = 0; e < 4; e++) begin
      wr(brt_pkg::ADDR_CTRL, 16'h0000);
      trig_req <= 1'b0;
      cyc(3);
      wr(brt_pkg::ADDR_CTRL, {6'h00, e[1:0], 8'h36});
      cyc(3);
      trig_req <= 1'b1;
      wait_hi(1'b1, 10, n);
      chk(n != 0, e[0]);
      if (n != 0) chk(n >= 4 && n <= 5, 16'h0001);
      else begin
        trig_req <= 1'b0;
        wait_hi(1'b1, 10, n);
        chk(n != 0, e == 2);
        if (n == 0) begin
          wr(brt_pkg::ADDR_CTRL, 16'h0037);
          wait_hi(1'b1, 10, n);
          chk(n != 0, 16'h0001);
        end
      end
    end
    // gate levels
    wr(brt_pkg::ADDR_STAT, 16'h8000);
    wr(brt_pkg::ADDR_CYCLE, 16'h0064);
    for (int e = 0; e < 4; e++) begin
      wr(brt_pkg::ADDR_CTRL, 16'h0000);
      trig_req <= ~e[0];
      cyc(3);
      wr(brt_pkg::ADDR_CTRL, {6'h00, e[1:0], 8'h33});
      cyc(4);
      rd(brt_pkg::ADDR_COUNT, a);
      rd(brt_pkg::ADDR_COUNT, b);
      chk(a, 16'h0064);
      chk(b, 16'h0064);
      trig_req <= e[0];
      cyc(5);
      rd(brt_pkg::ADDR_COUNT, a);
      rd(brt_pkg::ADDR_COUNT, b);
      chk(a - b, 16'h0002);
    end
    // wide mode counts only lower-channel underflows
    wr(brt_pkg::ADDR_STAT, 16'h0000);
    wr(brt_pkg::ADDR_CTRL, 16'h0000);
    wr(brt_pkg::ADDR_CYCLE, 16'h0010);
    wr(brt_pkg::ADDR_CTRL, 16'h00B3);
    cyc(4);
    rd(brt_pkg::ADDR_COUNT, a);
    chk(a, 16'h0010);
    repeat (3) begin
      @(posedge core_clk);
      chain_in <= 1'b1;
      @(posedge core_clk);
      chain_in <= 1'b0;
    end
    cyc(2);
    rd(brt_pkg::ADDR_COUNT, b);
    chk(b, 16'h000D);
    finish_test();
  end
endmodule
`default_nettype wire
